/* File: sector_lock_pkg.sv */
// Constants and types for the global sector protection decoder.
// Functional notes
// - Permitted write with bits 5..2 set protects all
// - Permitted write with bits 5..2 clear unprotects all
// - Mixed bits 5..2 leave protection unchanged
// - Pin low and lock set: only the latch clears
// - Lock clear: decode globally, load lock from bit7
// - Sector commands still work after global operation
// - Only bit 7 stored, bits 5..2 not kept
// - Pin high, lock set: block global, allow unlock
// - No write enable latch means no write
package sector_lock_pkg;

  localparam int NUM_SECTORS = 8;
  localparam int SECT_IDX_W  = 3;
  localparam int SECT_LSB    = 15;

  localparam logic [7:0] OP_WREN   = 8'h06;
  localparam logic [7:0] OP_WRDI   = 8'h04;
  localparam logic [7:0] OP_WRSR   = 8'h01;
  localparam logic [7:0] OP_PROT   = 8'h36;
  localparam logic [7:0] OP_UNPROT = 8'h39;

  localparam int LOCK_DATA_BIT = 7;
  localparam int GLOB_HI_BIT   = 5;
  localparam int GLOB_LO_BIT   = 2;

  localparam logic [3:0] WB_CTRL_ADDR = 4'h0;
  localparam logic [3:0] WB_STAT_ADDR = 4'h4;
  localparam int CTRL_EN_BIT   = 0;
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_WEL_BIT  = 1;
  localparam int STAT_WP_BIT   = 2;
  localparam int STAT_EN_BIT   = 3;
  localparam int STAT_SECT_LSB = 8;

  localparam logic                   CTRL_EN_RESET = 1'b1;
  localparam logic                   LOCK_RESET    = 1'b0;
  localparam logic                   WEL_RESET     = 1'b0;
  localparam logic [NUM_SECTORS-1:0] SECT_RESET    = 8'hff;

  typedef struct packed {
    logic                   lock;
    logic                   write_enable_latch;
    logic [NUM_SECTORS-1:0] sect;
  } prot_state_t;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic si;
    logic wp_n;
  } link_pins_t;

  localparam link_pins_t PINS_IDLE = '{sclk: 1'b0, cs_n: 1'b1,
                                      si: 1'b0, wp_n: 1'b1};

endpackage

/* File: global_sector_protect_decode.sv */
// Serial protection decoder with a Wishbone register slave.
`timescale 1ns/1ps
module global_sector_protect_decode
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        spi_sclk_i,
  input  wire logic        spi_cs_n_i,
  input  wire logic        spi_si_i,
  input  wire logic        wp_n_i,
  output logic      [7:0]  sector_prot_o,
  output logic             protection_lock_bit_o,
  output logic             write_enable_latch_o
);

  localparam int SECT_IDX_W_C = sector_lock_pkg::SECT_IDX_W;

  sector_lock_pkg::link_pins_t  meta_ff;
  sector_lock_pkg::link_pins_t  sync_ff;
  logic                         sclk_d_ff;
  logic                         cs_d_ff;
  logic [7:0]                   shift_ff;
  logic [7:0]                   nxt_shift;
  logic [2:0]                   bitcnt_ff;
  logic [2:0]                   nxt_bitcnt;
  logic [2:0]                   bytecnt_ff;
  logic [2:0]                   nxt_bytecnt;
  logic [7:0]                   op_ff;
  logic [7:0]                   nxt_op;
  logic [7:0]                   dat_ff;
  logic [7:0]                   nxt_dat;
  logic [23:0]                  addr_ff;
  logic [23:0]                  nxt_addr;
  sector_lock_pkg::prot_state_t prot_ff;
  sector_lock_pkg::prot_state_t nxt_prot;
  logic                         en_ff;
  logic                         nxt_en;
  logic                         ack_ff;
  logic                         nxt_ack;
  logic [31:0]                  rdat_ff;
  logic [31:0]                  nxt_rdat;
  logic                         sclk_rise;
  logic                         frame_end;
  logic                         aligned;
  logic                         hard_lock;
  logic [7:0]                   byte_in;
  logic [3:0]                   glob;
  logic [SECT_IDX_W_C-1:0]      sect_idx;

  assign byte_in   = {shift_ff[6:0], sync_ff.si};
  assign sclk_rise = sync_ff.sclk && !sclk_d_ff && !sync_ff.cs_n;
  assign frame_end = sync_ff.cs_n && !cs_d_ff;
  assign aligned   = (bitcnt_ff == 3'h0) && (bytecnt_ff != 3'h0);
  // Hard lock follows the lock held before this write.
  // prior lock value
  assign hard_lock = prot_ff.lock && !sync_ff.wp_n;
  assign glob      = dat_ff[sector_lock_pkg::GLOB_HI_BIT:
                            sector_lock_pkg::GLOB_LO_BIT];
  assign sect_idx  = addr_ff[sector_lock_pkg::SECT_LSB +: SECT_IDX_W_C];

  // Pins come from the host's domain, so each passes two flops first.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_ff   <= sector_lock_pkg::PINS_IDLE;
      sync_ff   <= sector_lock_pkg::PINS_IDLE;
      sclk_d_ff <= 1'b0;
      cs_d_ff   <= 1'b1;
    end
    else
    begin
      meta_ff   <= '{sclk: spi_sclk_i, cs_n: spi_cs_n_i,
                     si: spi_si_i, wp_n: wp_n_i};
      sync_ff   <= meta_ff;
      sclk_d_ff <= sync_ff.sclk;
      cs_d_ff   <= sync_ff.cs_n;
    end
  end

  always_comb
  begin
    nxt_shift   = shift_ff;
    nxt_bitcnt  = bitcnt_ff;
    nxt_bytecnt = bytecnt_ff;
    nxt_op      = op_ff;
    nxt_dat     = dat_ff;
    nxt_addr    = addr_ff;
    if (sync_ff.cs_n)
    begin
      nxt_bitcnt  = 3'h0;
      nxt_bytecnt = 3'h0;
    end
    else if (sclk_rise)
    begin
      nxt_shift  = byte_in;
      nxt_bitcnt = bitcnt_ff + 3'h1;
      if (bitcnt_ff == 3'h7)
      begin
        if (bytecnt_ff == 3'h0)
        begin
          nxt_op = byte_in;
        end
        else if (bytecnt_ff <= 3'h3)
        begin
          nxt_addr = {addr_ff[15:0], byte_in};
        end
        if (bytecnt_ff == 3'h1)
        begin
          nxt_dat = byte_in;
        end
        if (bytecnt_ff != 3'h4)
        begin
          nxt_bytecnt = bytecnt_ff + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      shift_ff   <= 8'h00;
      bitcnt_ff  <= 3'h0;
      bytecnt_ff <= 3'h0;
      op_ff      <= 8'h00;
      dat_ff     <= 8'h00;
      addr_ff    <= 24'h000000;
    end
    else
    begin
      shift_ff   <= nxt_shift;
      bitcnt_ff  <= nxt_bitcnt;
      bytecnt_ff <= nxt_bytecnt;
      op_ff      <= nxt_op;
      dat_ff     <= nxt_dat;
      addr_ff    <= nxt_addr;
    end
  end

  // Commands act only when the frame closes on a byte boundary, except that WRSR and the sector commands clear the latch on any close.
  always_comb
  begin
    nxt_prot = prot_ff;
    if (frame_end && en_ff)
    begin
      case (op_ff)
        sector_lock_pkg::OP_WREN:
        begin
          if (aligned)
          begin
            nxt_prot.write_enable_latch = 1'b1;
          end
        end
        sector_lock_pkg::OP_WRDI:
        begin
          if (aligned)
          begin
            nxt_prot.write_enable_latch = 1'b0;
          end
        end
        sector_lock_pkg::OP_WRSR:
        begin
          if (prot_ff.write_enable_latch)
          begin
            nxt_prot.write_enable_latch = 1'b0;
            if (aligned && bytecnt_ff >= 3'h2)
            begin
              if (!prot_ff.lock)
              begin
                if (glob == 4'hf)
                begin
                  nxt_prot.sect = sector_lock_pkg::SECT_RESET;
                end
                else if (glob == 4'h0)
                begin
                  nxt_prot.sect = '0;
                end
              end
              if (!hard_lock)
              begin
                nxt_prot.lock = dat_ff[sector_lock_pkg::LOCK_DATA_BIT];
              end
            end
          end
        end
        sector_lock_pkg::OP_PROT,
        sector_lock_pkg::OP_UNPROT:
        begin
          if (prot_ff.write_enable_latch)
          begin
            nxt_prot.write_enable_latch = 1'b0;
            if (aligned && bytecnt_ff == 3'h4 && !prot_ff.lock)
            begin
              nxt_prot.sect[sect_idx] = (op_ff == sector_lock_pkg::OP_PROT);
            end
          end
        end
        default:
        begin
          nxt_prot = prot_ff;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prot_ff <= '{lock: sector_lock_pkg::LOCK_RESET,
                   write_enable_latch: sector_lock_pkg::WEL_RESET,
                   sect: sector_lock_pkg::SECT_RESET};
    end
    else
    begin
      prot_ff <= nxt_prot;
    end
  end

  // Classic slave: ack one cycle after the request, write on the ack edge.
  always_comb
  begin
    nxt_ack  = wb_cyc_i && wb_stb_i && !ack_ff;
    nxt_en   = en_ff;
    nxt_rdat = 32'h00000000;
    if (wb_cyc_i && wb_stb_i && ack_ff && wb_we_i &&
        wb_adr_i == sector_lock_pkg::WB_CTRL_ADDR && wb_sel_i[0])
    begin
      nxt_en = wb_dat_i[sector_lock_pkg::CTRL_EN_BIT];
    end
    if (wb_adr_i == sector_lock_pkg::WB_CTRL_ADDR)
    begin
      nxt_rdat[sector_lock_pkg::CTRL_EN_BIT] = en_ff;
    end
    else if (wb_adr_i == sector_lock_pkg::WB_STAT_ADDR)
    begin
      nxt_rdat[sector_lock_pkg::STAT_LOCK_BIT] = prot_ff.lock;
      nxt_rdat[sector_lock_pkg::STAT_WEL_BIT]  = prot_ff.write_enable_latch;
      nxt_rdat[sector_lock_pkg::STAT_WP_BIT]   = sync_ff.wp_n;
      nxt_rdat[sector_lock_pkg::STAT_EN_BIT]   = en_ff;
      nxt_rdat[sector_lock_pkg::STAT_SECT_LSB +: 8] = prot_ff.sect;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff  <= 1'b0;
      en_ff   <= sector_lock_pkg::CTRL_EN_RESET;
      rdat_ff <= 32'h00000000;
    end
    else
    begin
      ack_ff  <= nxt_ack;
      en_ff   <= nxt_en;
      rdat_ff <= nxt_rdat;
    end
  end

  assign wb_ack_o              = ack_ff;
  assign wb_dat_o              = rdat_ff;
  assign sector_prot_o         = prot_ff.sect;
  assign protection_lock_bit_o = prot_ff.lock;
  assign write_enable_latch_o  = prot_ff.write_enable_latch;

endmodule

/* File: global_sector_protect_decode_chk.sv */
// Property checker for the global sector protection decoder.
`timescale 1ns/1ps
module global_sector_protect_decode_chk
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       spi_cs_n_i,
  input wire logic       wp_n_i,
  input wire logic [7:0] sector_prot_o,
  input wire logic       protection_lock_bit_o,
  input wire logic       write_enable_latch_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  locked_hold_a: assert property (
    protection_lock_bit_o |=> $stable(sector_prot_o))
    else $error("sectors moved while locked");
  // The decoder sees the pin two flops late, so look back two samples.
  hard_lock_a: assert property (
    $past(!wp_n_i, 2) && protection_lock_bit_o
      |=> protection_lock_bit_o)
    else $error("lock cleared with pin low");
  unlock_pin_a: assert property (
    $fell(protection_lock_bit_o) |-> $past(wp_n_i, 3))
    else $error("unlock with pin low");
  unlock_keep_a: assert property (
    $fell(protection_lock_bit_o) |-> $stable(sector_prot_o))
    else $error("global change under old lock");
  sect_latch_a: assert property (
    $changed(sector_prot_o)
      |-> $past(write_enable_latch_o) && !write_enable_latch_o)
    else $error("sector change without latch");
  lock_latch_a: assert property (
    $changed(protection_lock_bit_o) |-> $past(write_enable_latch_o))
    else $error("lock change without latch");
  frame_end_a: assert property (
    $changed(sector_prot_o) |-> spi_cs_n_i && $past(spi_cs_n_i))
    else $error("sector change inside frame");
  change_shape_a: assert property (
    $changed(sector_prot_o) |-> sector_prot_o inside {8'hff, 8'h00}
      || $onehot(sector_prot_o ^ $past(sector_prot_o)))
    else $error("sector change of odd shape");
  cover property ($changed(sector_prot_o) && sector_prot_o == 8'hff);
  cover property ($changed(sector_prot_o) && sector_prot_o == 8'h00);
  cover property ($fell(protection_lock_bit_o));
endmodule

bind global_sector_protect_decode global_sector_protect_decode_chk u_chk
(
  .clk_i(clk_i),
  .rst_i(rst_i),
  .spi_cs_n_i(spi_cs_n_i),
  .wp_n_i(wp_n_i),
  .sector_prot_o(sector_prot_o),
  .protection_lock_bit_o(protection_lock_bit_o),
  .write_enable_latch_o(write_enable_latch_o)
);

/* File: spi_host_model.sv */
// Serial host model that sends command frames to the decoder.
`timescale 1ns/1ps
module spi_host_model
(
  input  wire logic clk_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      si_o
);
  initial
  begin
    sclk_o = 1'h0;
    cs_n_o = 1'h1;
    si_o   = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // command frames
  // Only the leading n bits of d go out, so short frames can be made.
  task automatic frame(input logic [31:0] d, input int n);
    cs_n_o <= 1'h0;
    for (int i = 0; i < n; i++)
    begin
      si_o <= d[31-i];
      tick(4);
      sclk_o <= 1'h1;
      tick(4);
      sclk_o <= 1'h0;
    end
    tick(4);
    cs_n_o <= 1'h1;
    si_o   <= ~si_o;
    tick(12);
  endtask
endmodule

/* File: global_sector_protect_decode_bench.sv */
// Self-checking bench for the global sector protection decoder.
`timescale 1ns/1ps
module global_sector_protect_decode_bench;
  typedef struct packed {logic wp; logic [7:0] d; logic [7:0] s; logic l;}
    row_t;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        wb_req = 1'h0;
  logic        wb_we_i = 1'h0;
  logic [3:0]  wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] q;
  logic        wb_ack_o;
  logic        sclk;
  logic        cs_n;
  logic        si;
  logic        wp_n_i = 1'h1;
  logic [7:0]  sect;
  logic        lock;
  logic        latch;
  int          miscompares = 0;
  int          checks_done = 0;
  row_t        rows [11] = '{'{1'h1, 8'h43, 8'h00, 1'h0},
    '{1'h0, 8'h04, 8'h00, 1'h0}, '{1'h0, 8'h7f, 8'hff, 1'h0},
    '{1'h0, 8'h38, 8'hff, 1'h0}, '{1'h0, 8'hbc, 8'hff, 1'h1},
    '{1'h0, 8'h00, 8'hff, 1'h1}, '{1'h1, 8'h00, 8'hff, 1'h0},
    '{1'h1, 8'h80, 8'h00, 1'h1}, '{1'h1, 8'hbc, 8'h00, 1'h1},
    '{1'h1, 8'h3c, 8'h00, 1'h0}, '{1'h1, 8'h3c, 8'hff, 1'h0}};
  global_sector_protect_decode u_global_sector_protect_decode (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_req), .wb_stb_i(wb_req),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_si_i(si), .wp_n_i(wp_n_i),
    .sector_prot_o(sect), .protection_lock_bit_o(lock),
    .write_enable_latch_o(latch));
  spi_host_model u_spi_host_model (
    .clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si));
  initial
  begin
    forever #20 clk_i = ~clk_i;
  end
  task automatic finish_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic expect_state(input logic [7:0] s, input logic l);
    check({22'h0, lock, latch, sect}, {22'h0, l, 1'h0, s});
  endtask
  task automatic wb(input logic we, input logic [3:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_req   <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_i);
      if (wb_ack_o === 1'h1)
        break;
    end
    q = wb_dat_o;
    wb_req <= 1'h0;
    if (n == 20)
    begin
      miscompares++;
      finish_test;
    end
  endtask
  task automatic status_write(input logic [7:0] d, input int n);
    u_spi_host_model.frame({sector_lock_pkg::OP_WREN, 24'h0}, 8);
    u_spi_host_model.frame({sector_lock_pkg::OP_WRSR, d, 16'h0}, n);
  endtask
  initial
  begin
    repeat (100000) @(posedge clk_i);
    miscompares++;
    finish_test;
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    expect_state(8'hff, 1'h0);
    repeat (3) @(posedge clk_i);
    foreach (rows[i])
    begin
      wp_n_i <= rows[i].wp;
      status_write(rows[i].d, 16);
      expect_state(rows[i].s, rows[i].l);
    end
    u_spi_host_model.frame({sector_lock_pkg::OP_WRSR, 8'h00, 16'h0}, 16);
    expect_state(8'hff, 1'h0);
    u_spi_host_model.frame({sector_lock_pkg::OP_WREN, 24'h0}, 8);
    check({31'h0, latch}, 32'h1);
    u_spi_host_model.frame({sector_lock_pkg::OP_WRDI, 24'h0}, 8);
    u_spi_host_model.frame({sector_lock_pkg::OP_UNPROT, 24'h010000}, 32);
    expect_state(8'hff, 1'h0);
    u_spi_host_model.frame({sector_lock_pkg::OP_WREN, 24'h0}, 8);
    u_spi_host_model.frame({sector_lock_pkg::OP_UNPROT, 24'h010000}, 32);
    expect_state(8'hfb, 1'h0);
    u_spi_host_model.frame({sector_lock_pkg::OP_WREN, 24'h0}, 8);
    u_spi_host_model.frame({sector_lock_pkg::OP_UNPROT, 24'h000000}, 32);
    expect_state(8'hfa, 1'h0);
    u_spi_host_model.frame({sector_lock_pkg::OP_WREN, 24'h0}, 8);
    u_spi_host_model.frame({sector_lock_pkg::OP_PROT, 24'h000000}, 32);
    expect_state(8'hfb, 1'h0);
    // A status write cut short inside its data byte must be dropped.
    status_write(8'h3c, 12);
    expect_state(8'hfb, 1'h0);
    wb(1'h0, 4'h4, 32'h0);
    check(q, 32'h0000fb0c);
    wb(1'h0, 4'h8, 32'h0);
    check(q, 32'h0);
    wb(1'h1, 4'h0, 32'h0);
    wb(1'h0, 4'h0, 32'h0);
    check(q, 32'h0);
    status_write(8'h3c, 16);
    expect_state(8'hfb, 1'h0);
    finish_test;
  end
endmodule
